//--- bringup_pkg.sv
`default_nettype none
package bringup_pkg;
  // timing of the internal start-up sequence
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int STARTUP_TIME_NS = 10000;
  localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // strap vector positions
  localparam int STRAP_COUNT       = 6;
  localparam int STRAP_PD_IDX      = 0;
  localparam int STRAP_LEADER_IDX  = 1;
  localparam int STRAP_HI_SWING_IDX = 2;
  localparam int STRAP_SEL_LOW_IDX = 3;
  localparam int STRAP_SEL_HIGH_IDX = 4;
  localparam int STRAP_MEDIA_IDX   = 5;

  // management addresses
  localparam logic [4:0]  DEVAD_PMA      = 5'h01;
  localparam logic [4:0]  DEVAD_OWN      = 5'h1e;
  localparam logic [4:0]  DEVAD_VENDOR   = 5'h1f;
  localparam logic [15:0] ID_HIGH_ADDR   = 16'h0002;
  localparam logic [15:0] ID_LOW_ADDR    = 16'h0003;
  localparam logic [15:0] CTRL_ADDR      = 16'h0010;
  localparam logic [15:0] STATUS_ADDR    = 16'h0011;
  localparam logic [15:0] ADV_ADDR       = 16'h0012;

  // field positions
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_PD_BIT         = 1;
  localparam int CTRL_AN_EN_BIT      = 2;
  localparam int STAT_READY_BIT      = 0;
  localparam int STAT_PD_BIT         = 1;
  localparam int STAT_HI_ABLE_BIT    = 2;
  localparam int STAT_MAC_LSB        = 3;
  localparam int STAT_MEDIA_BIT      = 5;
  localparam int STAT_LEADER_BIT     = 6;
  localparam int ADV_HI_ABLE_BIT     = 0;
  localparam int ADV_HI_REQ_BIT      = 1;
  localparam int ADV_LEADER_BIT      = 2;
  localparam int ID_OUI_LSB          = 10;
  localparam int ID_MODEL_LSB        = 4;

  // values after reset
  localparam logic AN_EN_RESET      = 1'b1;
  localparam logic PD_RESET         = 1'b1;
  localparam logic ADV_HI_REQ_RESET = 1'b0;

  typedef enum logic [1:0] {
    MAC_RMII     = 2'b00,
    MAC_RGMII    = 2'b01,
    MAC_RESERVED = 2'b10,
    MAC_MII      = 2'b11
  } mac_iface_t;

  typedef enum logic [1:0] {
    SEQ_RESET = 2'b01,
    SEQ_READY = 2'b10
  } seq_state_t;
endpackage
`default_nettype wire

//--- strap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
  import bringup_pkg::*;
  logic                   capture;
  logic [STRAP_COUNT-1:0] strap_bits;
  modport sequencer (output capture);
  modport capturer  (input capture, output strap_bits);
  modport consumer  (input capture, input strap_bits);
endinterface
`default_nettype wire

//--- startup_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module startup_sequencer #(
  parameter int STARTUP_COUNT = bringup_pkg::STARTUP_CYCLES
) (
  input  wire logic   clock_in,
  input  wire logic   rst_in,
  input  wire logic   soft_reset_in,
  strap_if.sequencer  straps,
  output var  logic   ready_out
);
  import bringup_pkg::*;
  localparam int CW = $clog2(STARTUP_COUNT + 1);

  seq_state_t      state_reg, state_next;
  logic [CW-1:0]   count_reg, count_next;
  logic            capture_reg, capture_next;
  logic            ready_next;

  always_comb begin
    state_next   = state_reg;
    count_next   = count_reg;
    capture_next = 1'b0;
    ready_next   = 1'b0;
    case (state_reg)
      SEQ_RESET: begin
        if (count_reg == CW'(STARTUP_COUNT - 1)) begin
          state_next   = SEQ_READY;
          capture_next = 1'b1;
          count_next   = '0;
        end else begin
          count_next = count_reg + 1'b1;
        end
      end
      SEQ_READY: begin
        ready_next = !soft_reset_in;
        if (soft_reset_in) begin
          state_next = SEQ_RESET;
        end
      end
      default: begin
        state_next = SEQ_RESET;
        count_next = '0;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_reg   <= SEQ_RESET;
      count_reg   <= '0;
      capture_reg <= 1'b0;
      ready_out   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      count_reg   <= count_next;
      capture_reg <= capture_next;
      ready_out   <= ready_next;
    end
  end

  assign straps.capture = capture_reg;

  property p_soft_reset_drops_ready;
    @(posedge clock_in) disable iff (rst_in)
      soft_reset_in |=> !ready_out [*2];
  endproperty
  a_soft_reset_drops_ready: assert property (p_soft_reset_drops_ready)
    else $error("ready stayed high after soft reset");

  sequence s_capture;
    capture_reg;
  endsequence
  property p_ready_follows_capture;
    @(posedge clock_in) disable iff (rst_in)
      s_capture ##1 !soft_reset_in |=> ready_out;
  endproperty
  a_ready_follows_capture: assert property (p_ready_follows_capture)
    else $error("ready did not follow strap capture");
endmodule
`default_nettype wire

//--- strap_capture.sv
`timescale 1ns/1ps
`default_nettype none
module strap_capture #(
  parameter int WIDTH = bringup_pkg::STRAP_COUNT
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] pins_in,
  strap_if.capturer             straps
);
  import bringup_pkg::*;
  logic [WIDTH-1:0] sync1_reg, sync2_reg;
  logic [WIDTH-1:0] held_reg, held_next;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_sync
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          sync1_reg[i] <= 1'b0;
          sync2_reg[i] <= 1'b0;
        end else begin
          sync1_reg[i] <= pins_in[i];
          sync2_reg[i] <= sync1_reg[i];
        end
      end
    end
  endgenerate

  // later pin activity is ignored until the next capture
  always_comb begin
    held_next = straps.capture ? sync2_reg : held_reg;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      held_reg <= '0;
    end else begin
      held_reg <= held_next;
    end
  end

  // the capture edge hands over the freshly synchronised value, so the
  // configuration registers load this reset's straps and not the previous ones
  assign straps.strap_bits = held_next;

  property p_hold_between_captures;
    @(posedge clock_in) disable iff (rst_in)
      !straps.capture |=> $stable(held_reg);
  endproperty
  a_hold_between_captures: assert property (p_hold_between_captures)
    else $error("strap value changed outside capture");
endmodule
`default_nettype wire

//--- phy_bringup_config_control.sv
//  Behaviour
// - power-down strapped on stays forever unless management clears it
// - leader strap sets advertised leader or follower preference
// - high-swing strap low keeps both levels; high removes the high level
// - mac interface type comes from the two select straps
// - select pair decodes 00 rmii, 01 rgmii, 10 reserved, 11 mii
// - media converter strap enables converter only with rmii selected
// - identifier at register 2 and 3, clause 22 and 45, devad 1f or 01
// - identifier reads return zero until start-up has finished
// - identifier layout: vendor bits high word, vendor, model, revision low word
// - readable system-ready bit shows start-up complete
// - readable power-down status bit, its reset value from the strap
// - managed power-down holds until software activates, then autonegotiation may run
// - software clears the power-down control bit to leave power-down
// - autonegotiation enabled after reset
// - read-only high-swing ability loaded from strap at every reset
// - advertised high-swing ability accepts one only when ability reads one
// - advertised request bit prefers high level when one, low when zero
// - advertised ability zero forces resolution to the low level
`timescale 1ns/1ps
`default_nettype none
module phy_bringup_config_control #(
  parameter logic [15:0] VENDOR_ID_HIGH = 16'h0a5c, // arbitrary value
  parameter logic [5:0]  VENDOR_ID_LOW  = 6'h15,    // arbitrary value
  parameter logic [5:0]  MODEL_NUMBER   = 6'h03,    // arbitrary value
  parameter logic [3:0]  REVISION       = 4'h2,     // arbitrary value
  parameter int          STARTUP_COUNT  = bringup_pkg::STARTUP_CYCLES
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        powerdown_after_reset_strap_in,
  input  wire logic        leader_preference_strap_in,
  input  wire logic        high_swing_strap_in,
  input  wire logic        mac_iface_select_low_strap_in,
  input  wire logic        mac_iface_select_high_strap_in,
  input  wire logic        media_converter_strap_in,
  input  wire logic        mgmt_req_in,
  input  wire logic        mgmt_write_in,
  input  wire logic        mgmt_c45_in,
  input  wire logic [4:0]  mgmt_devad_in,
  input  wire logic [15:0] mgmt_regad_in,
  input  wire logic [15:0] mgmt_wdata_in,
  output var  logic [15:0] mgmt_rdata_out,
  output var  logic        mgmt_ack_out,
  output var  logic        system_ready_out,
  output var  logic        powered_down_out,
  output var  logic        an_enable_out,
  output var  logic        an_start_permit_out,
  output var  logic        adv_leader_out,
  output var  logic        adv_high_swing_ability_out,
  output var  logic        adv_high_swing_request_out,
  output var  logic        resolve_low_only_out,
  output var  bringup_pkg::mac_iface_t mac_iface_out,
  output var  logic        media_converter_out
);
  import bringup_pkg::*;

  strap_if straps ();
  logic                   ready;
  logic [STRAP_COUNT-1:0] pins;

  assign pins = {media_converter_strap_in, mac_iface_select_high_strap_in,
                 mac_iface_select_low_strap_in, high_swing_strap_in,
                 leader_preference_strap_in, powerdown_after_reset_strap_in};

  logic soft_reset_reg, soft_reset_next;

  startup_sequencer #(.STARTUP_COUNT(STARTUP_COUNT)) u_seq (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .soft_reset_in (soft_reset_reg),
    .straps        (straps.sequencer),
    .ready_out     (ready)
  );

  strap_capture #(.WIDTH(STRAP_COUNT)) u_cap (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .pins_in  (pins),
    .straps   (straps.capturer)
  );

  // clause 22 reaches the register directly, clause 45 through one of the devads
  function automatic logic addr_hit(input logic c45, input logic [4:0] devad,
                                    input logic [15:0] regad, input logic [15:0] target,
                                    input logic id_space);
    logic dev_ok;
    dev_ok = id_space ? (devad == DEVAD_VENDOR || devad == DEVAD_PMA)
                      : (devad == DEVAD_OWN);
    return (regad == target) && (!c45 || dev_ok);
  endfunction

  logic hit_id_high, hit_id_low, hit_ctrl, hit_status, hit_adv, wr_ok;
  always_comb begin
    hit_id_high = addr_hit(mgmt_c45_in, mgmt_devad_in, mgmt_regad_in, ID_HIGH_ADDR, 1'b1);
    hit_id_low  = addr_hit(mgmt_c45_in, mgmt_devad_in, mgmt_regad_in, ID_LOW_ADDR, 1'b1);
    hit_ctrl    = addr_hit(mgmt_c45_in, mgmt_devad_in, mgmt_regad_in, CTRL_ADDR, 1'b0);
    hit_status  = addr_hit(mgmt_c45_in, mgmt_devad_in, mgmt_regad_in, STATUS_ADDR, 1'b0);
    hit_adv     = addr_hit(mgmt_c45_in, mgmt_devad_in, mgmt_regad_in, ADV_ADDR, 1'b0);
    wr_ok       = mgmt_req_in && mgmt_write_in && ready && !soft_reset_reg;
  end

  // configuration state
  logic       pd_reg, pd_next;
  logic       an_en_reg, an_en_next;
  logic       ability_reg, ability_next;
  logic       adv_able_reg, adv_able_next;
  logic       adv_req_reg, adv_req_next;
  logic       adv_leader_reg, adv_leader_next;
  mac_iface_t mac_reg, mac_next;
  logic       media_reg, media_next;

  always_comb begin
    pd_next         = pd_reg;
    an_en_next      = an_en_reg;
    ability_next    = ability_reg;
    adv_able_next   = adv_able_reg;
    adv_req_next    = adv_req_reg;
    adv_leader_next = adv_leader_reg;
    mac_next        = mac_reg;
    media_next      = media_reg;
    soft_reset_next = 1'b0;
    if (straps.capture) begin
      // strap low selects power-down after reset
      pd_next         = !straps.strap_bits[STRAP_PD_IDX];
      an_en_next      = AN_EN_RESET;
      ability_next    = !straps.strap_bits[STRAP_HI_SWING_IDX];
      adv_able_next   = !straps.strap_bits[STRAP_HI_SWING_IDX];
      adv_req_next    = ADV_HI_REQ_RESET;
      adv_leader_next = straps.strap_bits[STRAP_LEADER_IDX];
      mac_next        = mac_iface_t'({straps.strap_bits[STRAP_SEL_HIGH_IDX],
                                      straps.strap_bits[STRAP_SEL_LOW_IDX]});
      media_next      = straps.strap_bits[STRAP_MEDIA_IDX];
    end else if (wr_ok && hit_ctrl) begin
      soft_reset_next = mgmt_wdata_in[CTRL_SOFT_RESET_BIT];
      pd_next         = mgmt_wdata_in[CTRL_PD_BIT];
      an_en_next      = mgmt_wdata_in[CTRL_AN_EN_BIT];
    end else if (wr_ok && hit_adv) begin
      adv_able_next   = mgmt_wdata_in[ADV_HI_ABLE_BIT] && ability_reg;
      adv_req_next    = mgmt_wdata_in[ADV_HI_REQ_BIT] && ability_reg;
      adv_leader_next = mgmt_wdata_in[ADV_LEADER_BIT];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pd_reg         <= PD_RESET;
      an_en_reg      <= AN_EN_RESET;
      ability_reg    <= 1'b0;
      adv_able_reg   <= 1'b0;
      adv_req_reg    <= ADV_HI_REQ_RESET;
      adv_leader_reg <= 1'b0;
      mac_reg        <= MAC_RMII;
      media_reg      <= 1'b0;
      soft_reset_reg <= 1'b0;
    end else begin
      pd_reg         <= pd_next;
      an_en_reg      <= an_en_next;
      ability_reg    <= ability_next;
      adv_able_reg   <= adv_able_next;
      adv_req_reg    <= adv_req_next;
      adv_leader_reg <= adv_leader_next;
      mac_reg        <= mac_next;
      media_reg      <= media_next;
      soft_reset_reg <= soft_reset_next;
    end
  end

  // read path and registered outputs
  logic [15:0] rdata_next, status_word, id_low_word;
  logic        permit_next, media_out_next;

  always_comb begin
    id_low_word = {VENDOR_ID_LOW, MODEL_NUMBER, REVISION};
    status_word = '0;
    status_word[STAT_READY_BIT]                 = ready;
    status_word[STAT_PD_BIT]                    = pd_reg;
    status_word[STAT_HI_ABLE_BIT]               = ability_reg;
    status_word[STAT_MAC_LSB +: 2]              = mac_reg;
    status_word[STAT_MEDIA_BIT]                 = media_reg;
    status_word[STAT_LEADER_BIT]                = adv_leader_reg;
    rdata_next = '0;
    if (mgmt_req_in && !mgmt_write_in) begin
      if (hit_id_high) begin
        rdata_next = ready ? VENDOR_ID_HIGH : '0;
      end else if (hit_id_low) begin
        rdata_next = ready ? id_low_word : '0;
      end else if (hit_ctrl) begin
        rdata_next = {13'h0000, an_en_reg, pd_reg, 1'b0};
      end else if (hit_status) begin
        rdata_next = status_word;
      end else if (hit_adv) begin
        rdata_next = {13'h0000, adv_leader_reg, adv_req_reg, adv_able_reg};
      end
    end
    permit_next    = ready && !pd_reg && an_en_reg;
    media_out_next = media_reg && (mac_reg == MAC_RMII);
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mgmt_rdata_out             <= '0;
      mgmt_ack_out               <= 1'b0;
      system_ready_out           <= 1'b0;
      powered_down_out           <= PD_RESET;
      an_enable_out              <= AN_EN_RESET;
      an_start_permit_out        <= 1'b0;
      adv_leader_out             <= 1'b0;
      adv_high_swing_ability_out <= 1'b0;
      adv_high_swing_request_out <= ADV_HI_REQ_RESET;
      resolve_low_only_out       <= 1'b1;
      mac_iface_out              <= MAC_RMII;
      media_converter_out        <= 1'b0;
    end else begin
      mgmt_rdata_out             <= rdata_next;
      mgmt_ack_out               <= mgmt_req_in;
      system_ready_out           <= ready;
      powered_down_out           <= pd_reg;
      an_enable_out              <= an_en_reg;
      an_start_permit_out        <= permit_next;
      adv_leader_out             <= adv_leader_reg;
      adv_high_swing_ability_out <= adv_able_reg;
      adv_high_swing_request_out <= adv_req_reg;
      resolve_low_only_out       <= !adv_able_reg;
      mac_iface_out              <= mac_reg;
      media_converter_out        <= media_out_next;
    end
  end

  property p_id_zero_until_ready;
    @(posedge clock_in) disable iff (rst_in)
      mgmt_req_in && !mgmt_write_in && (hit_id_high || hit_id_low) && !ready
      |=> mgmt_rdata_out == 16'h0000;
  endproperty
  a_id_zero_until_ready: assert property (p_id_zero_until_ready)
    else $error("identifier visible before start-up finished");

  property p_able_needs_ability;
    @(posedge clock_in) disable iff (rst_in)
      !ability_reg |-> ##1 !adv_high_swing_ability_out;
  endproperty
  a_able_needs_ability: assert property (p_able_needs_ability)
    else $error("high-swing advertised without ability");

  property p_low_only;
    @(posedge clock_in) disable iff (rst_in)
      !adv_able_reg |=> resolve_low_only_out;
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("low-only resolution not forced");

  property p_media_rmii;
    @(posedge clock_in) disable iff (rst_in)
      media_converter_out |-> mac_iface_out == MAC_RMII;
  endproperty
  a_media_rmii: assert property (p_media_rmii)
    else $error("media converter outside rmii");

  property p_pd_holds;
    @(posedge clock_in) disable iff (rst_in)
      pd_reg && !straps.capture && !(wr_ok && hit_ctrl) |=> pd_reg;
  endproperty
  a_pd_holds: assert property (p_pd_holds)
    else $error("power-down left without management write");

  property p_pd_from_strap;
    @(posedge clock_in) disable iff (rst_in)
      straps.capture |=> ##1 powered_down_out == !$past(straps.strap_bits[STRAP_PD_IDX], 2);
  endproperty
  a_pd_from_strap: assert property (p_pd_from_strap)
    else $error("power-down status does not follow strap");

  property p_an_gated;
    @(posedge clock_in) disable iff (rst_in)
      an_start_permit_out |-> !$past(pd_reg) && $past(ready);
  endproperty
  a_an_gated: assert property (p_an_gated)
    else $error("autonegotiation permitted while powered down");
endmodule
`default_nettype wire

//--- x_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- mgmt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_model (
  input  wire logic        clock_in,
  input  wire logic [15:0] mgmt_rdata_in,
  input  wire logic        mgmt_ack_in,
  output var  logic        mgmt_req_out,
  output var  logic        mgmt_write_out,
  output var  logic        mgmt_c45_out,
  output var  logic [4:0]  mgmt_devad_out,
  output var  logic [15:0] mgmt_regad_out,
  output var  logic [15:0] mgmt_wdata_out,
  output var  logic [5:0]  strap_out
);
  import bringup_pkg::*;
  initial begin
    mgmt_req_out   = 1'b0;
    mgmt_write_out = 1'b0;
    mgmt_c45_out   = 1'b0;
    mgmt_devad_out = 5'h00;
    mgmt_regad_out = 16'h0000;
    mgmt_wdata_out = 16'h0000;
    strap_out      = 6'h00;
  end
  // straps change well before a soft reset ends, or after capture to show they are ignored
  task automatic set_straps(input logic pd, input logic ld, input logic hs,
                            input logic sh, input logic sl, input logic mc);
    @(posedge clock_in);
    strap_out[STRAP_PD_IDX]       <= pd;
    strap_out[STRAP_LEADER_IDX]   <= ld;
    strap_out[STRAP_HI_SWING_IDX] <= hs;
    strap_out[STRAP_SEL_HIGH_IDX] <= sh;
    strap_out[STRAP_SEL_LOW_IDX]  <= sl;
    strap_out[STRAP_MEDIA_IDX]    <= mc;
  endtask
  // one frame: request pulse, answer looked at in the ack cycle, then release
  task automatic access(input logic wr, input logic c45, input logic [4:0] dv,
                        input logic [15:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
    @(posedge clock_in);
    mgmt_req_out   <= 1'b1;
    mgmt_write_out <= wr;
    mgmt_c45_out   <= c45;
    mgmt_devad_out <= dv;
    mgmt_regad_out <= ra;
    mgmt_wdata_out <= wd;
    @(posedge clock_in);
    mgmt_req_out <= 1'b0;
    #1;
    ok = (mgmt_ack_in === 1'b1);
    rd = mgmt_rdata_in;
    @(posedge clock_in);
    // released fields other than c45 carry no stale copy of the last frame
    mgmt_write_out <= ~wr;
    mgmt_devad_out <= ~dv;
    mgmt_regad_out <= ~ra;
    mgmt_wdata_out <= ~wd;
  endtask
endmodule
`default_nettype wire

//--- phy_bringup_config_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module phy_bringup_config_control_tb;
  import bringup_pkg::*;
  localparam logic [15:0] VID_HI = 16'h5a3c; // arbitrary value
  localparam logic [5:0]  VID_LO = 6'h2b;    // arbitrary value
  localparam logic [5:0]  MODEL  = 6'h11;    // arbitrary value
  localparam logic [3:0]  REV    = 4'h6;     // arbitrary value
  logic        clock_in, rst_in, req, wr, c45, ack, rdy, pd, an_en, permit;
  logic        leader, ab, rq, low_only, media, ok;
  logic [4:0]  devad;
  logic [15:0] regad, wdata, rdata, rd;
  logic [5:0]  straps;
  mac_iface_t  mac;
  int          err_count, n_compared, cycles;
  phy_bringup_config_control #(.VENDOR_ID_HIGH(VID_HI), .VENDOR_ID_LOW(VID_LO),
    .MODEL_NUMBER(MODEL), .REVISION(REV), .STARTUP_COUNT(4)) u_dut (
    .clock_in(clock_in), .rst_in(rst_in),
    .powerdown_after_reset_strap_in(straps[STRAP_PD_IDX]),
    .leader_preference_strap_in(straps[STRAP_LEADER_IDX]),
    .high_swing_strap_in(straps[STRAP_HI_SWING_IDX]),
    .mac_iface_select_low_strap_in(straps[STRAP_SEL_LOW_IDX]),
    .mac_iface_select_high_strap_in(straps[STRAP_SEL_HIGH_IDX]),
    .media_converter_strap_in(straps[STRAP_MEDIA_IDX]),
    .mgmt_req_in(req), .mgmt_write_in(wr), .mgmt_c45_in(c45), .mgmt_devad_in(devad),
    .mgmt_regad_in(regad), .mgmt_wdata_in(wdata), .mgmt_rdata_out(rdata),
    .mgmt_ack_out(ack), .system_ready_out(rdy), .powered_down_out(pd),
    .an_enable_out(an_en), .an_start_permit_out(permit), .adv_leader_out(leader),
    .adv_high_swing_ability_out(ab), .adv_high_swing_request_out(rq),
    .resolve_low_only_out(low_only), .mac_iface_out(mac), .media_converter_out(media));
  mgmt_host_model u_host (
    .clock_in(clock_in), .mgmt_rdata_in(rdata), .mgmt_ack_in(ack), .mgmt_req_out(req),
    .mgmt_write_out(wr), .mgmt_c45_out(c45), .mgmt_devad_out(devad),
    .mgmt_regad_out(regad), .mgmt_wdata_out(wdata), .strap_out(straps));
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_reg(input logic c, input logic [4:0] dv, input logic [15:0] ra,
                        input logic [15:0] mask, input logic [15:0] exp);
    u_host.access(1'b0, c, dv, ra, 16'h0000, rd, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(rd & mask, exp);
  endtask
  task automatic wr_reg(input logic [15:0] ra, input logic [15:0] wd);
    u_host.access(1'b1, 1'b0, 5'h00, ra, wd, rd, ok);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  task automatic wait_ready(input logic lvl);
    int i;
    #1;
    for (i = 0; i < 40 && rdy !== lvl; i++) begin
      @(posedge clock_in);
      #1;
    end
    chk({15'h0000, rdy}, {15'h0000, lvl});
  endtask
  // order: power-down, an enable, start permit, leader, ability, request, low only, media
  task automatic chk_cfg(input logic [7:0] exp);
    repeat (2) @(posedge clock_in);
    #1;
    chk({8'h00, pd, an_en, permit, leader, ab, rq, low_only, media}, {8'h00, exp});
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    logic [1:0] code;
    rst_in     = 1'b1;
    cycles     = 0;
    err_count  = 0;
    n_compared = 0;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    rd_reg(1'b0, 5'h00, ID_HIGH_ADDR, 16'hffff, 16'h0000);
    wait_ready(1'b1);
    rd_reg(1'b0, 5'h00, STATUS_ADDR, 16'hffff, 16'h0007);
    chk_cfg(8'hc8);
    chk({14'h0000, mac}, {14'h0000, MAC_RMII});
    for (int k = 0; k < 3; k++) begin
      rd_reg(k != 0, (k == 2) ? DEVAD_VENDOR : DEVAD_PMA, ID_HIGH_ADDR, 16'hffff, VID_HI);
      rd_reg(k != 0, (k == 2) ? DEVAD_VENDOR : DEVAD_PMA, ID_LOW_ADDR, 16'hffff,
             {VID_LO, MODEL, REV});
    end
    u_host.set_straps(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (20) @(posedge clock_in);
    chk_cfg(8'hc8);
    chk({14'h0000, mac}, {14'h0000, MAC_RMII});
    rd_reg(1'b0, 5'h00, 16'h0030, 16'hffff, 16'h0000);
    wr_reg(CTRL_ADDR, 16'h0004);
    chk_cfg(8'h68);
    rd_reg(1'b0, 5'h00, STATUS_ADDR, 16'hffff, 16'h0005);
    wr_reg(ADV_ADDR, 16'h0003);
    chk_cfg(8'h6c);
    wr_reg(ADV_ADDR, 16'h0000);
    chk_cfg(8'h62);
    for (int k = 0; k < 4; k++) begin
      code = k[1:0];
      u_host.set_straps(1'b1, 1'b1, 1'b1, code[1], code[0], 1'b1);
      wr_reg(CTRL_ADDR, 16'h0001);
      wait_ready(1'b0);
      wait_ready(1'b1);
      chk({14'h0000, mac}, {14'h0000, code});
      chk({15'h0000, media}, {15'h0000, code == 2'b00});
      chk_cfg({7'h39, code == 2'b00});
      rd_reg(1'b0, 5'h00, STATUS_ADDR, 16'hffff, {9'h000, 1'b1, 1'b1, code, 3'b001});
    end
    wr_reg(ADV_ADDR, 16'h0007);
    chk_cfg(8'h72);
    end_sim();
  end
endmodule
`default_nettype wire
